// file: logic/eli_defines.svh
// constants for the ethernet link indicator logic
`ifndef ELI_DEFINES_SVH
`define ELI_DEFINES_SVH

// speed codes from the controller
`define ELI_SPEED_10    2'h0
`define ELI_SPEED_100   2'h1
`define ELI_SPEED_1000  2'h2
`define ELI_SPEED_NONE  2'h3

// media pair roles
`define ELI_PAIR_IDLE   2'h0
`define ELI_PAIR_TX     2'h1
`define ELI_PAIR_RX     2'h2
`define ELI_PAIR_BIDI   2'h3

// pulse-per-second timing at 10 MHz
`define ELI_CLOCK_HZ    10000000
`define ELI_PPS_PERIOD_S 1
`define ELI_PPS_CYCLES  (`ELI_CLOCK_HZ * `ELI_PPS_PERIOD_S)
`define ELI_PPS_HIGH_US 100
`define ELI_PPS_HIGH_CYCLES ((`ELI_CLOCK_HZ / 1000000) * `ELI_PPS_HIGH_US)

// soft pin modes
`define ELI_SDP_INPUT   2'h0
`define ELI_SDP_OUTPUT  2'h1
`define ELI_SDP_PPS     2'h2

`endif

// file: logic/eli_pkg.sv
// types for the ethernet link indicator logic
`default_nettype none
package eli_pkg;
   typedef enum logic [1:0] {
      ELI_SPD_10   = 2'h0,
      ELI_SPD_100  = 2'h1,
      ELI_SPD_1000 = 2'h2,
      ELI_SPD_NONE = 2'h3
   } eli_speed_e;

   typedef enum logic [1:0] {
      ELI_SDP_IN  = 2'h0,
      ELI_SDP_OUT = 2'h1,
      ELI_SDP_PPS = 2'h2,
      ELI_SDP_RSV = 2'h3
   } eli_sdp_mode_e;

   typedef enum logic [1:0] {
      ELI_PAIR_IDLE = 2'h0,
      ELI_PAIR_TX   = 2'h1,
      ELI_PAIR_RX   = 2'h2,
      ELI_PAIR_BIDI = 2'h3
   } eli_pair_e;
endpackage : eli_pkg
`default_nettype wire

// file: logic/eli_pps_gen.sv
// one pulse per second generator for the soft pin
`default_nettype none
`include "eli_defines.svh"
module eli_pps_gen
   import eli_pkg::*;
#(
   parameter int unsigned PERIOD_CYCLES = `ELI_PPS_CYCLES,
   parameter int unsigned HIGH_CYCLES   = `ELI_PPS_HIGH_CYCLES
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic enable,
   output var  logic pulse
);
   typedef struct packed {
      logic [31:0] count;
      logic        pulse;
   } eli_pps_s;

   eli_pps_s st_q;
   eli_pps_s st_d;

   always_comb begin
      st_d = st_q;
      if (!enable) begin
         st_d.count = 32'h0000_0000;
         st_d.pulse = 1'b0;
      end else begin
         if (st_q.count >= PERIOD_CYCLES - 1) begin
            st_d.count = 32'h0000_0000;
         end else begin
            st_d.count = st_q.count + 32'h0000_0001;
         end
         st_d.pulse = (st_d.count < HIGH_CYCLES);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pulse = st_q.pulse;
endmodule : eli_pps_gen
`default_nettype wire

// file: logic/eli_link_indicator.sv
// link, activity and soft pin logic of the ethernet controller
`default_nettype none
`include "eli_defines.svh"
module eli_link_indicator
   import eli_pkg::*;
#(
   parameter int unsigned PPS_PERIOD_CYCLES = `ELI_PPS_CYCLES,
   parameter int unsigned PPS_HIGH_CYCLES   = `ELI_PPS_HIGH_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       link_up,
   input  wire logic [1:0] link_speed,
   input  wire logic       tx_active,
   input  wire logic       rx_active,
   input  wire logic [1:0] sdp_mode,
   input  wire logic       sdp_out_value,
   input  wire logic       eth_soft_defined_pin_i,
   output var  logic       eth_soft_defined_pin_o,
   output var  logic       eth_soft_defined_pin_oe,
   output var  logic       sdp_in_value,
   output var  logic       eth_activity_led_n_o,
   output var  logic       eth_activity_led_n_oe,
   output var  logic       eth_link_fast_led_n_o,
   output var  logic       eth_link_fast_led_n_oe,
   output var  logic       eth_link_gigabit_led_n_o,
   output var  logic       eth_link_gigabit_led_n_oe,
   output var  logic       eth_link_any_led_n_o,
   output var  logic       eth_link_any_led_n_oe,
   output var  logic [1:0] media_pair0_role,
   output var  logic [1:0] media_pair1_role,
   output var  logic [1:0] media_pair2_role,
   output var  logic [1:0] media_pair3_role
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       act_oe;
      logic       fast_oe;
      logic       giga_oe;
      logic       any_oe;
      logic       sdp_o;
      logic       sdp_oe;
      logic       sdp_in;
      logic [1:0] pair0;
      logic [1:0] pair1;
      logic [1:0] pair2;
      logic [1:0] pair3;
   } eli_state_s;

   eli_state_s st_q;
   eli_state_s st_d;
   logic       pps_pulse;
   logic       fast_n;
   logic       giga_n;
   eli_speed_e speed;
   eli_sdp_mode_e mode;

   assign speed = eli_speed_e'(link_speed);
   assign mode  = eli_sdp_mode_e'(sdp_mode);

   // ----------------------------------------------------------------
   // pulse generator
   // ----------------------------------------------------------------
   eli_pps_gen #(
      .PERIOD_CYCLES (PPS_PERIOD_CYCLES),
      .HIGH_CYCLES   (PPS_HIGH_CYCLES)
   ) u_pps (
      .clock  (clock),
      .rst    (rst),
      .enable (mode == ELI_SDP_PPS),
      .pulse  (pps_pulse)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // active-low speed levels before the open-drain stage
      fast_n = ~(link_up && speed == ELI_SPD_100);
      giga_n = ~(link_up && speed == ELI_SPD_1000);
      st_d.fast_oe = ~fast_n;
      st_d.giga_oe = ~giga_n;
      // no 10 Mb/s level feeds the AND, so 10 Mb/s stays dark
      st_d.any_oe  = ~(fast_n & giga_n);
      st_d.act_oe  = tx_active | rx_active;
      case (speed)
         ELI_SPD_1000: begin
            st_d.pair0 = ELI_PAIR_BIDI;
            st_d.pair1 = ELI_PAIR_BIDI;
            st_d.pair2 = ELI_PAIR_BIDI;
            st_d.pair3 = ELI_PAIR_BIDI;
         end
         ELI_SPD_100, ELI_SPD_10: begin
            st_d.pair0 = ELI_PAIR_TX;
            st_d.pair1 = ELI_PAIR_RX;
            st_d.pair2 = ELI_PAIR_IDLE;
            st_d.pair3 = ELI_PAIR_IDLE;
         end
         default: begin
            st_d.pair0 = ELI_PAIR_IDLE;
            st_d.pair1 = ELI_PAIR_IDLE;
            st_d.pair2 = ELI_PAIR_IDLE;
            st_d.pair3 = ELI_PAIR_IDLE;
         end
      endcase
      if (!link_up) begin
         st_d.pair0 = ELI_PAIR_IDLE;
         st_d.pair1 = ELI_PAIR_IDLE;
         st_d.pair2 = ELI_PAIR_IDLE;
         st_d.pair3 = ELI_PAIR_IDLE;
      end
      st_d.sdp_in = eth_soft_defined_pin_i;
      case (mode)
         ELI_SDP_OUT: begin
            st_d.sdp_o  = sdp_out_value;
            st_d.sdp_oe = 1'b1;
         end
         ELI_SDP_PPS: begin
            st_d.sdp_o  = pps_pulse;
            st_d.sdp_oe = 1'b1;
         end
         default: begin
            st_d.sdp_o  = 1'b0;
            st_d.sdp_oe = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // open-drain pins only ever drive low
   assign eth_activity_led_n_o      = 1'b0;
   assign eth_link_fast_led_n_o     = 1'b0;
   assign eth_link_gigabit_led_n_o  = 1'b0;
   assign eth_link_any_led_n_o      = 1'b0;
   assign eth_activity_led_n_oe     = st_q.act_oe;
   assign eth_link_fast_led_n_oe    = st_q.fast_oe;
   assign eth_link_gigabit_led_n_oe = st_q.giga_oe;
   assign eth_link_any_led_n_oe     = st_q.any_oe;
   assign eth_soft_defined_pin_o    = st_q.sdp_o;
   assign eth_soft_defined_pin_oe   = st_q.sdp_oe;
   assign sdp_in_value              = st_q.sdp_in;
   assign media_pair0_role          = st_q.pair0;
   assign media_pair1_role          = st_q.pair1;
   assign media_pair2_role          = st_q.pair2;
   assign media_pair3_role          = st_q.pair3;
endmodule : eli_link_indicator
`default_nettype wire

// file: tb/eli_link_checker.sv
// assertions on the ethernet link indicator ports
`default_nettype none
module eli_link_checker
   import eli_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       link_up,
   input wire logic [1:0] link_speed,
   input wire logic       tx_active,
   input wire logic       rx_active,
   input wire logic [1:0] sdp_mode,
   input wire logic       sdp_out_value,
   input wire logic       eth_soft_defined_pin_o,
   input wire logic       eth_soft_defined_pin_oe,
   input wire logic       eth_activity_led_n_oe,
   input wire logic       eth_link_fast_led_n_oe,
   input wire logic       eth_link_gigabit_led_n_oe,
   input wire logic       eth_link_any_led_n_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   any_and_a: assert property (
      eth_link_any_led_n_oe ==
      (eth_link_fast_led_n_oe | eth_link_gigabit_led_n_oe))
      else $error("combined link not and of speeds");
   ten_dark_a: assert property (
      link_up && link_speed == ELI_SPD_10 |=> !eth_link_any_led_n_oe)
      else $error("combined link lit at 10");
   act_follow_a: assert property (
      1'b1 |=> eth_activity_led_n_oe == $past(tx_active | rx_active))
      else $error("activity not following traffic");
   fast_on_a: assert property (
      link_up && link_speed == ELI_SPD_100 |=>
      eth_link_fast_led_n_oe && !eth_link_gigabit_led_n_oe)
      else $error("fast link indicator wrong");
   giga_on_a: assert property (
      link_up && link_speed == ELI_SPD_1000 |=>
      eth_link_gigabit_led_n_oe && !eth_link_fast_led_n_oe)
      else $error("gigabit link indicator wrong");
   no_link_a: assert property (
      !link_up |=> !eth_link_any_led_n_oe && !eth_link_fast_led_n_oe &&
      !eth_link_gigabit_led_n_oe)
      else $error("link indicator lit without link");
   sdp_drive_a: assert property (
      sdp_mode == ELI_SDP_OUT |=> eth_soft_defined_pin_oe &&
      eth_soft_defined_pin_o == $past(sdp_out_value))
      else $error("soft pin not driving value");
   sdp_pps_a: assert property (
      sdp_mode == ELI_SDP_PPS |=> eth_soft_defined_pin_oe)
      else $error("soft pin not driving pulse");
   cover property (link_up && link_speed == ELI_SPD_1000);
   cover property (sdp_mode == ELI_SDP_PPS && eth_soft_defined_pin_o);
   cover property ($fell(eth_link_any_led_n_oe));
endmodule : eli_link_checker
bind eli_link_indicator eli_link_checker chk (.*);
`default_nettype wire

// file: tb/eli_carrier_model.sv
// carrier board: led pull-ups and the soft pin wire
`default_nettype none
module eli_carrier_model (
   input  wire logic [3:0] led_o,
   input  wire logic [3:0] led_oe,
   input  wire logic       sdp_o,
   input  wire logic       sdp_oe,
   input  wire logic       ext_val,
   output wire logic [3:0] led_lvl,
   output wire logic       pin_lvl
);
   timeunit 1ns;
   timeprecision 1ns;
   assign led_lvl = (led_oe & led_o) | ~led_oe;
   assign pin_lvl = sdp_oe ? sdp_o : ext_val;
endmodule : eli_carrier_model
`default_nettype wire

// file: tb/eli_link_indicator_bench.sv
// self-checking bench for the ethernet link indicator logic
`default_nettype none
module eli_link_indicator_bench import eli_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PERIOD = 20;
   localparam int HIGH   = 3;
   logic        clock, rst, link_up, tx_active, rx_active, sdp_out_value;
   logic        ext_val, pin_lvl, sdp_o, sdp_oe, sdp_in_value;
   logic [1:0]  link_speed, sdp_mode, p0, p1, p2, p3;
   logic [3:0]  led_o, led_oe, led_lvl;
   int          bad_count, compares, cnt;
   // inputs, leds {fast,giga,any,act}, roles {p0,p1,p2,p3}
   logic [16:0] rows [6] = '{{5'h16, 4'h4, 8'h60}, {5'h19, 4'h8, 8'hff},
      {5'h10, 4'hf, 8'h60}, {5'h0b, 4'he, 8'h00}, {5'h14, 4'h5, 8'h60},
      {5'h1b, 4'h8, 8'hff}};
   eli_link_indicator #(.PPS_PERIOD_CYCLES(PERIOD),
      .PPS_HIGH_CYCLES(HIGH)) uut (.clock, .rst, .link_up, .link_speed,
      .tx_active, .rx_active, .sdp_mode, .sdp_out_value, .sdp_in_value,
      .eth_soft_defined_pin_i(pin_lvl), .eth_soft_defined_pin_o(sdp_o),
      .eth_soft_defined_pin_oe(sdp_oe), .eth_activity_led_n_o(led_o[0]),
      .eth_activity_led_n_oe(led_oe[0]), .eth_link_any_led_n_o(led_o[1]),
      .eth_link_any_led_n_oe(led_oe[1]), .eth_link_fast_led_n_o(led_o[3]),
      .eth_link_fast_led_n_oe(led_oe[3]),
      .eth_link_gigabit_led_n_o(led_o[2]),
      .eth_link_gigabit_led_n_oe(led_oe[2]), .media_pair0_role(p0),
      .media_pair1_role(p1), .media_pair2_role(p2), .media_pair3_role(p3));
   eli_carrier_model cm (.led_o, .led_oe, .sdp_o, .sdp_oe, .ext_val,
      .led_lvl, .pin_lvl);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic tick(int n);
      repeat (n) @(negedge clock);
   endtask : tick
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic complete_run;
      if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      {link_up, link_speed, tx_active, rx_active} = '0;
      {sdp_mode, sdp_out_value, ext_val} = '0;
      rst = 1'b1;
      tick(5);
      chk("reset leds", 8'h0f, {4'h0, led_lvl});
      rst = 1'b0;
      foreach (rows[i]) begin
         {link_up, link_speed, tx_active, rx_active} = rows[i][16:12];
         tick(1);
         chk("leds", {4'h0, rows[i][11:8]}, {4'h0, led_lvl});
         chk("pairs", rows[i][7:0], {p0, p1, p2, p3});
      end
      rst = 1'b1;
      #1 chk("mid reset leds", 8'h0f, {4'h0, led_lvl});
      chk("mid reset pairs", 8'h00, {p0, p1, p2, p3});
      tick(1);
      rst = 1'b0;
      for (int v = 1; v >= 0; v--) begin
         {sdp_mode, sdp_out_value, ext_val} = {ELI_SDP_OUT, v[0], ~v[0]};
         tick(1);
         chk("pin out", {7'h0, v[0]}, {7'h0, pin_lvl});
      end
      for (int m = 0; m < 4; m += 3) begin
         {sdp_mode, ext_val} = {m[1:0], 1'b1};
         tick(2);
         chk("pin in", 8'h01, {sdp_oe, sdp_in_value});
      end
      {sdp_mode, ext_val} = {ELI_SDP_PPS, 1'b0};
      tick(2);
      cnt = 0;
      repeat (2 * PERIOD) begin
         tick(1);
         cnt += pin_lvl;
      end
      chk("pps highs", 8'(2 * HIGH), cnt[7:0]);
      complete_run();
   end
endmodule : eli_link_indicator_bench
`default_nettype wire
